// ===== verilog/cra_responder.sv
// Configuration register access responder: parses token-framed read and write
// messages, performs the access on a back-end register port, and answers.
// Also serves processor status reads and writes through the same back-end.
// Assumes the register storage sits outside, behind reg_req/reg_ack.
`timescale 1ns/100ps
`default_nettype none
`include "cra_defs.svh"

// Notes on behaviour
// - PS read/write moves one full word.
// - Config write: 192, reply id, reg16, data32, 1.
// - Config read: 193, reply id, reg16, 1.
// - Peripheral write: 36, id, reg8, size, data, 1.
// - Peripheral read: 37, id, reg8, size8, 1.
// - Write reply is 3,1 on success, 4,1 failure.
// - Config read reply 3, data32, 1; else 4,1.
// - Peripheral read reply 3, data, 1; else 4,1.
module cra_responder
  import cra_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Incoming request tokens
  input wire logic tok_in_valid,
  input wire cra_tok_s tok_in,
  output logic tok_in_ready,
  // Outgoing reply tokens and their destination
  output logic tok_out_valid,
  output cra_tok_s tok_out,
  input wire logic tok_out_ready,
  output logic [23:0] reply_dest,
  // Processor status access
  input wire logic ps_valid,
  input wire logic ps_wr,
  input wire logic [31:0] ps_rid,
  input wire logic [31:0] ps_wdata,
  output logic ps_ready,
  output logic ps_done,
  output logic ps_err,
  output logic [31:0] ps_rdata,
  // Back-end register port
  output logic reg_req,
  output cra_req_s reg_out,
  input wire logic reg_ack,
  input wire logic reg_err,
  input wire logic [31:0] reg_rdata
);

  typedef enum logic [3:0] {ST_IDLE = 4'h0, ST_DEST = 4'h1, ST_REG = 4'h2, ST_SIZE = 4'h3, ST_DATA = 4'h4,
    ST_TAIL = 4'h5, ST_ACCESS = 4'h6, ST_HDR = 4'h7, ST_SEND = 4'h8, ST_CLOSE = 4'h9} cra_st_e;
  typedef enum logic [1:0] {K_CFG_WR = 2'h0, K_CFG_RD = 2'h1, K_PER_WR = 2'h2, K_PER_RD = 2'h3} cra_kind_e;
  typedef enum logic [1:0] {BK_IDLE = 2'h0, BK_MSG = 2'h1, BK_PS = 2'h2} cra_bk_e;

  cra_st_e st_r, st_nxt;
  cra_kind_e kind_r, kind_nxt;
  cra_bk_e bk_r, bk_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic [23:0] dest_r, dest_nxt;
  logic [15:0] addr_r, addr_nxt;
  logic [7:0] size_r, size_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic bad_r, bad_nxt;
  logic ok_r, ok_nxt;
  cra_req_s ps_req_r;
  logic ps_done_r, ps_err_r;
  logic [31:0] ps_rdata_r;

  function automatic logic is_header(input logic [7:0] v);
    is_header = (v == `CRA_TOK_CFG_WR) || (v == `CRA_TOK_CFG_RD) ||
                (v == `CRA_TOK_PER_WR) || (v == `CRA_TOK_PER_RD);
  endfunction : is_header

  ////////////////////////////////////////////////////////////////////////////
  wire logic receiving = (st_r <= ST_TAIL);
  wire logic take = tok_in_valid && tok_in_ready;
  wire logic take_data = take && !tok_in.ctrl;
  wire logic take_end = take && tok_in.ctrl && (tok_in.val == `CRA_TOK_END);
  wire logic take_other_ctrl = take && tok_in.ctrl && (tok_in.val != `CRA_TOK_END);
  wire logic is_wr = !kind_r[0];
  wire logic is_per = kind_r[1];
  wire cra_kind_e hdr_kind =
    (tok_in.val == `CRA_TOK_CFG_WR) ? K_CFG_WR :
    (tok_in.val == `CRA_TOK_CFG_RD) ? K_CFG_RD :
    (tok_in.val == `CRA_TOK_PER_WR) ? K_PER_WR : K_PER_RD;
  wire logic [7:0] data_len = is_per ? size_r : `CRA_WORD_BYTES;
  wire logic [7:0] cnt_inc = cnt_r + `CRA_CNT_ONE;
  wire logic [7:0] reg_last = is_per ? `CRA_PER_REG_LAST : `CRA_CFG_REG_LAST;
  // Peripheral transfers beyond one word cannot be carried by the back-end
  wire logic size_bad = is_per && (size_r > `CRA_WORD_BYTES);
  wire logic [4:0] align_sh = {3'(`CRA_WORD_BYTES - data_len), 2'b00};
  wire logic [5:0] align_bits = {align_sh, 1'b0};
  wire logic ps_tag_ok = (ps_rid[7:0] == `CRA_PS_TAG);
  wire logic [15:0] ps_num = ps_rid[`CRA_PS_SHIFT +: 16];
  wire logic ps_take = ps_valid && ps_ready;
  wire logic msg_ack = reg_ack && (bk_r == BK_MSG);
  wire logic ps_ack = reg_ack && (bk_r == BK_PS);

  assign tok_in_ready = receiving;
  // A message waiting for the back-end takes precedence over a new PS access
  assign ps_ready = (bk_r == BK_IDLE) && (st_r != ST_ACCESS);
  assign reg_req = (bk_r != BK_IDLE);
  assign reg_out = (bk_r == BK_PS) ? ps_req_r :
    '{wr: is_wr, space: is_per ? CRA_SP_PER : CRA_SP_CFG, addr: addr_r, wdata: wdata_r, size: size_r};
  assign tok_out_valid = (st_r == ST_HDR) || (st_r == ST_SEND) || (st_r == ST_CLOSE);
  assign tok_out = '{ctrl: st_r != ST_SEND, val: (st_r == ST_SEND) ? rdata_r[31:24] :
    (st_r == ST_HDR) ? (ok_r ? `CRA_TOK_ACK : `CRA_TOK_NACK) : `CRA_TOK_END};
  assign reply_dest = dest_r;
  assign ps_done = ps_done_r;
  assign ps_err = ps_err_r;
  assign ps_rdata = ps_rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_nxt = st_r;
    kind_nxt = kind_r;
    {cnt_nxt, dest_nxt, addr_nxt, size_nxt, wdata_nxt, rdata_nxt, bad_nxt, ok_nxt} =
      {cnt_r, dest_r, addr_r, size_r, wdata_r, rdata_r, bad_r, ok_r};
    if (st_r != ST_IDLE && receiving && take_other_ctrl) begin
      bad_nxt = 1'b1;
    end
    // Closing token ends the message wherever it falls; early means failure
    if (st_r != ST_IDLE && receiving && take_end) begin
      ok_nxt = 1'b0;
      st_nxt = (bad_r || st_r != ST_TAIL || size_bad) ? ST_HDR : ST_ACCESS;
    end
    unique case (st_r)
      ST_IDLE: begin
        // Stray tokens between messages are dropped
        if (take && tok_in.ctrl && is_header(tok_in.val)) begin
          kind_nxt = hdr_kind;
          cnt_nxt = `CRA_CNT_ZERO;
          bad_nxt = 1'b0;
          size_nxt = `CRA_WORD_BYTES;
          st_nxt = ST_DEST;
        end
      end
      ST_DEST: begin
        if (take_data) begin
          dest_nxt = {dest_r[15:0], tok_in.val};
          cnt_nxt = cnt_inc;
          if (cnt_r == `CRA_DEST_LAST) begin
            cnt_nxt = `CRA_CNT_ZERO;
            st_nxt = ST_REG;
          end
        end
      end
      ST_REG: begin
        if (take_data) begin
          addr_nxt = {addr_r[7:0], tok_in.val};
          cnt_nxt = cnt_inc;
          if (cnt_r == reg_last) begin
            cnt_nxt = `CRA_CNT_ZERO;
            if (is_per) begin
              addr_nxt = {8'h00, tok_in.val};
              st_nxt = ST_SIZE;
            end else begin
              st_nxt = is_wr ? ST_DATA : ST_TAIL;
            end
          end
        end
      end
      ST_SIZE: begin
        if (take_data) begin
          size_nxt = tok_in.val;
          st_nxt = (is_wr && tok_in.val != `CRA_CNT_ZERO) ? ST_DATA : ST_TAIL;
        end
      end
      ST_DATA: begin
        if (take_data) begin
          wdata_nxt = {wdata_r[23:0], tok_in.val};
          cnt_nxt = cnt_inc;
          if (cnt_inc == data_len) begin
            st_nxt = ST_TAIL;
          end
        end
      end
      ST_TAIL: begin
        if (take_data) begin
          bad_nxt = 1'b1;
        end
      end
      ST_ACCESS: begin
        if (msg_ack) begin
          ok_nxt = !reg_err;
          // First reply byte lands in the top lane
          rdata_nxt = reg_rdata << align_bits;
          st_nxt = ST_HDR;
        end
      end
      ST_HDR: begin
        if (tok_out_ready) begin
          cnt_nxt = `CRA_CNT_ZERO;
          st_nxt = (ok_r && !is_wr && data_len != `CRA_CNT_ZERO) ? ST_SEND : ST_CLOSE;
        end
      end
      ST_SEND: begin
        if (tok_out_ready) begin
          rdata_nxt = {rdata_r[23:0], 8'h00};
          cnt_nxt = cnt_inc;
          if (cnt_inc == data_len) begin
            st_nxt = ST_CLOSE;
          end
        end
      end
      ST_CLOSE: begin
        if (tok_out_ready) begin
          st_nxt = ST_IDLE;
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    bk_nxt = bk_r;
    unique case (bk_r)
      BK_IDLE: bk_nxt = (st_r == ST_ACCESS) ? BK_MSG : (ps_take && ps_tag_ok) ? BK_PS : BK_IDLE;
      BK_MSG, BK_PS: bk_nxt = reg_ack ? BK_IDLE : bk_r;
      default: bk_nxt = BK_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      st_r <= ST_IDLE;
      kind_r <= K_CFG_WR;
      bk_r <= BK_IDLE;
      {cnt_r, dest_r, addr_r, wdata_r, rdata_r, bad_r, ok_r} <= '0;
      size_r <= `CRA_WORD_BYTES;
    end else begin
      st_r <= st_nxt;
      kind_r <= kind_nxt;
      bk_r <= bk_nxt;
      {cnt_r, dest_r, addr_r, size_r, wdata_r, rdata_r, bad_r, ok_r} <=
        {cnt_nxt, dest_nxt, addr_nxt, size_nxt, wdata_nxt, rdata_nxt, bad_nxt, ok_nxt};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      ps_req_r <= '0;
      ps_done_r <= 1'b0;
      ps_err_r <= 1'b0;
      ps_rdata_r <= 32'h00000000;
    end else begin
      ps_done_r <= ps_ack || (ps_take && !ps_tag_ok);
      if (ps_take) begin
        ps_req_r <= '{wr: ps_wr, space: CRA_SP_PS, addr: ps_num, wdata: ps_wdata, size: `CRA_WORD_BYTES};
        ps_err_r <= !ps_tag_ok;
      end
      if (ps_ack) begin
        ps_err_r <= reg_err;
        ps_rdata_r <= reg_rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  a_ps_bad_tag: assert property (@(posedge clk_sys) disable iff (!nrst)
    ps_take && !ps_tag_ok |=> ps_done && ps_err && !reg_req) else $error("bad PS tag not refused");
  a_ps_reg_number: assert property (@(posedge clk_sys) disable iff (!nrst)
    ps_take && ps_tag_ok |=> reg_req && reg_out.space == CRA_SP_PS && reg_out.addr == 16'($past(ps_rid) >> 8))
    else $error("PS access to wrong register");
  a_write_kind: assert property (@(posedge clk_sys) disable iff (!nrst)
    reg_req && bk_r == BK_MSG |-> reg_out.wr == (kind_r == K_CFG_WR || kind_r == K_PER_WR))
    else $error("access direction mismatches header");
  a_early_end_nack: assert property (@(posedge clk_sys) disable iff (!nrst)
    st_r != ST_IDLE && st_r != ST_TAIL && take_end |=> tok_out_valid && tok_out.val == `CRA_TOK_NACK)
    else $error("truncated message not refused");
  a_ok_ack_token: assert property (@(posedge clk_sys) disable iff (!nrst)
    msg_ack && !reg_err |=> tok_out_valid && tok_out.ctrl && tok_out.val == `CRA_TOK_ACK)
    else $error("success reply not token 3");
  a_err_nack_token: assert property (@(posedge clk_sys) disable iff (!nrst)
    msg_ack && reg_err |=> tok_out_valid && tok_out.ctrl && tok_out.val == `CRA_TOK_NACK)
    else $error("failure reply not token 4");
  a_nack_then_end: assert property (@(posedge clk_sys) disable iff (!nrst)
    st_r == ST_HDR && !ok_r && tok_out_ready |=> tok_out_valid && tok_out.ctrl && tok_out.val == `CRA_TOK_END)
    else $error("failure reply not closed by token 1");
  a_cfg_read_bytes: assert property (@(posedge clk_sys) disable iff (!nrst)
    st_r == ST_HDR && ok_r && kind_r == K_CFG_RD && tok_out_ready |=> st_r == ST_SEND && cnt_r == 8'h00)
    else $error("config read data not sent");
  a_dest_stable: assert property (@(posedge clk_sys) disable iff (!nrst)
    tok_out_valid |-> !tok_in_ready && $stable(reply_dest)) else $error("reply before close or dest moved");

endmodule : cra_responder
`default_nettype wire

// ===== verilog/cra_defs.svh
// Constants for the configuration register access responder.
// Assumes inclusion by bare name; holds definitions only.
`ifndef CRA_DEFS_SVH
`define CRA_DEFS_SVH

// Header control tokens of request messages
`define CRA_TOK_CFG_WR 8'hC0
`define CRA_TOK_CFG_RD 8'hC1
`define CRA_TOK_PER_WR 8'h24
`define CRA_TOK_PER_RD 8'h25
// Reply and closing control tokens
`define CRA_TOK_ACK 8'h03
`define CRA_TOK_NACK 8'h04
`define CRA_TOK_END 8'h01
// Processor status resource identifier layout
`define CRA_PS_TAG 8'h0C
`define CRA_PS_SHIFT 8
// Field lengths in bytes, minus one where used as a last index
`define CRA_DEST_LAST 8'h02
`define CRA_CFG_REG_LAST 8'h01
`define CRA_PER_REG_LAST 8'h00
`define CRA_WORD_BYTES 8'h04
`define CRA_CNT_ZERO 8'h00
`define CRA_CNT_ONE 8'h01

`endif

// ===== verilog/cra_pkg.sv
// Types shared by the configuration register access responder.
// Assumes nothing beyond a SystemVerilog compiler.
package cra_pkg;

  // One interconnect token: control flag and eight bits
  typedef struct packed {
    logic ctrl;
    logic [7:0] val;
  } cra_tok_s;

  // Register spaces behind the back-end port
  typedef enum logic [1:0] {
    CRA_SP_PS = 2'h0,
    CRA_SP_CFG = 2'h1,
    CRA_SP_PER = 2'h2
  } cra_space_e;

  // One back-end register access
  typedef struct packed {
    logic wr;
    cra_space_e space;
    logic [15:0] addr;
    logic [31:0] wdata;
    logic [7:0] size;
  } cra_req_s;

endpackage : cra_pkg

// ===== bench/cra_reg_model.sv
// Back-end register store that answers the responder's register port.
// Assumes one access at a time; acks after 0 to 3 idle cycles.
`timescale 1ns/100ps
`default_nettype none
module cra_reg_model
  import cra_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Register port
  input wire logic reg_req,
  input wire cra_req_s reg_out,
  output logic reg_ack,
  output logic reg_err,
  output logic [31:0] reg_rdata
);
  logic [31:0] mem [0:255];
  logic [1:0] wait_r;
  wire [7:0] idx = {reg_out.space, reg_out.addr[5:0]};
  // Low bytes F0 and above stand for a failing register
  wire bad = reg_out.addr[7:4] == 4'hF;
  always @(posedge clk_sys) begin
    if (!nrst) begin
      reg_ack <= 1'b0;
      reg_err <= 1'b0;
      reg_rdata <= 32'hA5C3_5A3C;
      wait_r <= 2'h0;
      for (int i = 0; i < 256; i++) mem[i] <= 32'h0;
    end else if (reg_ack || !reg_req) begin
      reg_ack <= 1'b0;
      // Data lines toggle when idle so stale data never passes
      reg_rdata <= ~reg_rdata;
      if (reg_ack) wait_r <= 2'($urandom % 4);
    end else if (wait_r != 2'h0) begin
      wait_r <= wait_r - 2'h1;
    end else begin
      reg_ack <= 1'b1;
      reg_err <= bad;
      reg_rdata <= mem[idx];
      if (reg_out.wr && !bad) mem[idx] <= reg_out.wdata;
    end
  end
endmodule : cra_reg_model
`default_nettype wire

// ===== bench/config_register_access_protocol_bench.sv
// Self-checking bench for the configuration register access responder.
// Assumes cra_reg_model behind the back-end port; replies checked in order.
`timescale 1ns/100ps
`default_nettype none
`include "cra_defs.svh"
module config_register_access_protocol_bench;
  import cra_pkg::*;
  logic clk_sys, nrst, tok_in_valid, tok_out_ready, ps_valid, ps_wr;
  logic tok_in_ready, tok_out_valid, ps_ready, ps_done, ps_err, reg_req, reg_ack, reg_err;
  cra_tok_s tok_in, tok_out;
  cra_req_s reg_out;
  logic [23:0] reply_dest;
  logic [31:0] ps_rid, ps_wdata, ps_rdata, reg_rdata;
  cra_tok_s exp_q[$];
  logic [23:0] dest_q[$];
  logic [33:0] ps_q[$];
  logic [31:0] shadow [0:255];
  int mismatches, n_tests;

  cra_responder dut (.clk_sys, .nrst, .tok_in_valid, .tok_in, .tok_in_ready, .tok_out_valid,
    .tok_out, .tok_out_ready, .reply_dest, .ps_valid, .ps_wr, .ps_rid, .ps_wdata, .ps_ready,
    .ps_done, .ps_err, .ps_rdata, .reg_req, .reg_out, .reg_ack, .reg_err, .reg_rdata);
  cra_reg_model model (.clk_sys, .nrst, .reg_req, .reg_out, .reg_ack, .reg_err, .reg_rdata);

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    if (mismatches == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict

  task automatic chk(string what, logic [33:0] exp, logic [33:0] got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Ready is sampled at the falling edge, so it is the value the next rising edge sees
  task automatic wait_ready(input bit ps);
    int k;
    k = 0;
    @(negedge clk_sys);
    while (ps ? ps_ready !== 1'b1 : tok_in_ready !== 1'b1) begin
      k++;
      if (k > 500) begin
        mismatches++;
        print_verdict();
      end
      @(negedge clk_sys);
    end
    @(posedge clk_sys);
  endtask : wait_ready

  // Valid stays up between tokens, so back-to-back messages need no gap
  task automatic send(logic c, logic [7:0] v);
    tok_in_valid <= 1'b1;
    tok_in <= '{c, v};
    wait_ready(0);
  endtask : send

  task automatic msg(logic [7:0] h, logic [23:0] dst, logic [15:0] rg, int rb, int sz,
                     logic [31:0] d, int db);
    send(1'b1, h);
    for (int i = 2; i >= 0; i--) send(1'b0, dst[i*8+:8]);
    for (int i = rb - 1; i >= 0; i--) send(1'b0, rg[i*8+:8]);
    if (sz >= 0) send(1'b0, 8'(sz));
    for (int i = db - 1; i >= 0; i--) send(1'b0, d[i*8+:8]);
    send(1'b1, 8'h01);
  endtask : msg

  task automatic expect_reply(logic [23:0] dst, logic ok, logic [31:0] d, int nb);
    exp_q.push_back('{1'b1, ok ? 8'h03 : 8'h04});
    if (ok) for (int i = nb - 1; i >= 0; i--) exp_q.push_back('{1'b0, d[i*8+:8]});
    exp_q.push_back('{1'b1, 8'h01});
    dest_q.push_back(dst);
  endtask : expect_reply

  task automatic ps(logic wr, logic [31:0] rid, logic [31:0] wd, logic [33:0] e);
    ps_q.push_back(e);
    ps_valid <= 1'b1;
    ps_wr <= wr;
    ps_rid <= rid;
    ps_wdata <= wd;
    wait_ready(1);
    ps_valid <= 1'b0;
    @(posedge clk_sys);
  endtask : ps

  ////////////////////////////////////////////////////////////////////////
  always @(posedge clk_sys) tok_out_ready <= ($urandom % 4) != 0;

  always @(negedge clk_sys) begin : watch
    cra_tok_s e;
    logic [33:0] p;
    if (nrst && tok_out_valid && tok_out_ready) begin
      if (exp_q.size() == 0) chk("tok_extra", 34'h0, 34'h1);
      else begin
        e = exp_q.pop_front();
        chk("tok_out", 34'(e), 34'(tok_out));
        if (e == cra_tok_s'{1'b1, 8'h01}) chk("reply_dest", 34'(dest_q.pop_front()), 34'(reply_dest));
      end
    end
    if (nrst && ps_done && ps_q.size() == 0) chk("ps_extra", 34'h0, 34'h1);
    else if (nrst && ps_done) begin
      p = ps_q.pop_front();
      chk("ps_err", 34'(p[32]), 34'(ps_err));
      if (p[33]) chk("ps_rdata", 34'(p[31:0]), 34'(ps_rdata));
    end
  end

  initial begin : main
    logic [23:0] dst;
    logic [15:0] rg;
    logic [31:0] d, pd, rid, dummy;
    logic [7:0] pr, ci, pi;
    logic bad;
    int sz, k;
    {nrst, tok_in_valid, ps_valid, ps_wr} = 4'h0;
    tok_in = '0;
    {ps_rid, ps_wdata} = 64'h0;
    tok_out_ready = 1'b1;
    for (int i = 0; i < 256; i++) shadow[i] = 32'h0;
    dummy = $urandom(44);
    repeat (12) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    for (int n = 0; n < 12; n++) begin
      dst = 24'($urandom);
      d = $urandom;
      rg = {8'($urandom), 2'h0, 6'($urandom)};
      bad = (n % 4) == 3;
      if (bad) rg[7:4] = 4'hF;
      ci = {2'h1, rg[5:0]};
      expect_reply(dst, !bad, 32'h0, 0);
      msg(8'hC0, dst, rg, 2, -1, d, 4);
      if (!bad) shadow[ci] = d;
      expect_reply(dst, !bad, shadow[ci], 4);
      msg(8'hC1, dst, rg, 2, -1, 32'h0, 0);
      sz = 1 + n % 4;
      pr = rg[7:0];
      pi = {2'h2, pr[5:0]};
      pd = (sz == 4) ? d : d & ((32'h1 << (8 * sz)) - 32'h1);
      expect_reply(dst, !bad, 32'h0, 0);
      msg(8'h24, dst, 16'(pr), 1, sz, pd, sz);
      if (!bad) shadow[pi] = pd;
      expect_reply(dst, !bad, shadow[pi], sz);
      msg(8'h25, dst, 16'(pr), 1, sz, 32'h0, 0);
    end
    // Closing token where the register number belongs
    expect_reply(dst, 1'b0, 32'h0, 0);
    msg(8'hC1, dst, 16'h0, 0, -1, 32'h0, 0);
    // Stray data after the register number, oversize and empty peripheral reads
    expect_reply(dst, 1'b0, 32'h0, 0);
    msg(8'hC1, dst, 16'h0001, 2, -1, 32'h5A, 1);
    expect_reply(dst, 1'b0, 32'h0, 0);
    msg(8'h25, dst, 16'h0001, 1, 5, 32'h0, 0);
    expect_reply(dst, 1'b1, 32'h0, 0);
    msg(8'h25, dst, 16'h0001, 1, 0, 32'h0, 0);
    tok_in_valid <= 1'b0;
    for (int n = 0; n < 4; n++) begin
      rg = 16'($urandom % 64);
      d = $urandom;
      rid = (32'(rg) << 8) | 32'h0C;
      ps(1'b1, rid, d, 34'h0);
      ps(1'b0, rid, 32'h0, {2'b10, d});
      ps(1'b0, rid ^ 32'h1, 32'h0, {2'b01, 32'h0});
    end
    k = 0;
    while ((exp_q.size() != 0 || ps_q.size() != 0) && k < 2000) begin
      k++;
      @(posedge clk_sys);
    end
    if (k >= 2000) mismatches++;
    print_verdict();
  end
endmodule : config_register_access_protocol_bench
`default_nettype wire
